/* dfcr_regs.sv */
// Purpose: steering-word and software output gate registers of the oscillator
// Assumes: serial link already decoded into word writes and reads
// Notes:   offset out is in units of 2^-25 ppm of full scale
//
// Summary of operation
// (R1) low word at 0x00, sixteen bits read/write
// (R2) high ten bits at 0x01 bits 9:0
// (R3) power-up clears the whole steering word
// (R4) steering word is signed two's complement
// (R5) host writes low word before high
// (R6) only high word write starts change
// (R7) writes accepted any time after power-up
// (R8) bit 10 of 0x01 gates the output
// (R9) hardware gate mode ignores bit 10 writes
// (R10) bits 15:11 of 0x01 read zero
// (R11) pull range code maps to full-scale ppm
// (R12) pull starts within 140 us, settles 20 us
// (R13) host keeps gate bit set on writes; the bench register loop writes a random bit 10 to 0x01
// (R14) offset equals word over 2^25 times range
// (R15) low and high words captured together
`timescale 1ns/1ns
`default_nettype none
module dfcr_regs
(
  // clock and reset
  input  wire  logic               core_clk_in,
  input  wire  logic               rst_in,
  // register access
  input  wire  logic               reg_wr_in,
  input  wire  logic               reg_rd_in,
  input  wire  logic [7:0]         reg_addr_in,
  input  wire  logic [15:0]        reg_wdata_in,
  output var   logic [15:0]        reg_rdata_out,
  // configuration
  input  wire  logic               hw_gate_mode_in,
  input  wire  logic [3:0]         pull_range_in,
  // oscillator side
  output var   logic               output_gate_out,
  output var   logic [25:0]        applied_steer_out,
  output var   logic signed [37:0] freq_offset_out,
  output var   logic               pull_busy_out,
  output var   logic               pull_settled_out
);

  function automatic logic [11:0] range_ppm(input logic [3:0] code);
    case (code)
      4'h3:    range_ppm = 12'h019;
      4'h4:    range_ppm = 12'h032;
      4'h5:    range_ppm = 12'h050;
      4'h6:    range_ppm = 12'h064;
      4'hd:    range_ppm = 12'h4b0;
      4'he:    range_ppm = 12'h640;
      4'hf:    range_ppm = 12'hc80;
      default: range_ppm = 12'h000; // unused codes pull nothing
    endcase
  endfunction

  logic [15:0]                 low_steer_word;
  logic [9:0]                  high_steer_word;
  logic                        output_gate;
  logic [25:0]                 applied_steer;
  logic [15:0]                 next_low_steer_word;
  logic [9:0]                  next_high_steer_word;
  logic                        next_output_gate;
  logic [25:0]                 next_applied_steer;
  logic [15:0]                 rdata;
  logic [15:0]                 next_rdata;
  dfcr_pkg::dfcr_state_t       state;
  dfcr_pkg::dfcr_state_t       next_state;
  logic [dfcr_pkg::CNT_W-1:0]  cnt;
  logic [dfcr_pkg::CNT_W-1:0]  next_cnt;
  logic signed [37:0]          offset;
  logic signed [37:0]          next_offset;
  logic                        wr_low;
  logic                        wr_high;
  logic signed [37:0]          steer_ext;
  logic signed [37:0]          ppm_ext;

  // both factors widened to the full offset width so the product cannot overflow
  assign steer_ext = {{12{applied_steer[25]}}, applied_steer}; // R4
  assign ppm_ext   = {26'h0000000, range_ppm(pull_range_in)}; // R11

  assign wr_low  = reg_wr_in && (reg_addr_in == dfcr_pkg::ADDR_LOW_WORD);
  assign wr_high = reg_wr_in && (reg_addr_in == dfcr_pkg::ADDR_HIGH_WORD);

  always_comb
  begin
    next_low_steer_word  = low_steer_word;
    next_high_steer_word = high_steer_word;
    next_output_gate     = output_gate;
    next_applied_steer   = applied_steer;
    next_rdata           = rdata;
    if (wr_low)
    begin
      next_low_steer_word = reg_wdata_in; // R1 R7
    end
    if (wr_high)
    begin
      next_high_steer_word = reg_wdata_in[dfcr_pkg::HIGH_FIELD_W-1:0]; // R2 R7
      // pair taken with the incoming high word, never a stale mix
      next_applied_steer = {reg_wdata_in[dfcr_pkg::HIGH_FIELD_W-1:0], low_steer_word}; // R6 R15 R5
      if (!hw_gate_mode_in)
      begin
        next_output_gate = reg_wdata_in[dfcr_pkg::OE_BIT]; // R8 R9 R13
      end
    end
    if (reg_rd_in)
    begin
      case (reg_addr_in)
        dfcr_pkg::ADDR_LOW_WORD:  next_rdata = low_steer_word;
        dfcr_pkg::ADDR_HIGH_WORD: next_rdata = {5'h00, output_gate, high_steer_word}; // R10
        default:                  next_rdata = dfcr_pkg::RESET_WORD;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      low_steer_word  <= dfcr_pkg::RESET_WORD; // R3
      high_steer_word <= 10'h000; // R3
      output_gate     <= 1'b0; // R8
      applied_steer   <= dfcr_pkg::RESET_STEER; // R3
      rdata           <= dfcr_pkg::RESET_WORD;
    end
    else
    begin
      low_steer_word  <= next_low_steer_word;
      high_steer_word <= next_high_steer_word;
      output_gate     <= next_output_gate;
      applied_steer   <= next_applied_steer;
      rdata           <= next_rdata;
    end
  end

  // pull timing: worst-case delay then settle, restarted by each high write
  always_comb
  begin
    next_state  = state;
    next_cnt    = cnt;
    next_offset = offset;
    case (state)
      dfcr_pkg::DFCR_IDLE:
      begin
        next_cnt = '0;
      end
      dfcr_pkg::DFCR_DELAY:
      begin
        next_cnt = cnt + 15'h0001;
        if (cnt == 15'(dfcr_pkg::DELAY_CYCLES - 1)) // R12
        begin
          next_state  = dfcr_pkg::DFCR_SETTLE;
          next_cnt    = '0;
          // offset = signed word * ppm, read as ppm scaled by 2^-25
          next_offset = steer_ext * ppm_ext; // R4 R11 R14
        end
      end
      dfcr_pkg::DFCR_SETTLE:
      begin
        next_cnt = cnt + 15'h0001;
        if (cnt == 15'(dfcr_pkg::SETTLE_CYCLES - 1)) // R12
        begin
          next_state = dfcr_pkg::DFCR_IDLE;
          next_cnt   = '0;
        end
      end
      default:
      begin
        next_state = dfcr_pkg::DFCR_IDLE;
      end
    endcase
    if (wr_high)
    begin
      next_state = dfcr_pkg::DFCR_DELAY; // R6
      next_cnt   = '0;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state  <= dfcr_pkg::DFCR_IDLE;
      cnt    <= '0;
      offset <= '0; // R3
    end
    else
    begin
      state  <= next_state;
      cnt    <= next_cnt;
      offset <= next_offset;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pull_busy_out    <= 1'b0;
      pull_settled_out <= 1'b1;
    end
    else
    begin
      pull_busy_out    <= (next_state != dfcr_pkg::DFCR_IDLE);
      pull_settled_out <= (next_state == dfcr_pkg::DFCR_IDLE);
    end
  end

  assign reg_rdata_out     = rdata;
  assign output_gate_out   = output_gate;
  assign applied_steer_out = applied_steer;
  assign freq_offset_out   = offset;

  sequence s_high_wr;
    reg_wr_in && reg_addr_in == dfcr_pkg::ADDR_HIGH_WORD;
  endsequence

  sequence s_low_only;
    reg_wr_in && reg_addr_in == dfcr_pkg::ADDR_LOW_WORD;
  endsequence

  AST_LOW_STORE: assert property (@(posedge core_clk_in) disable iff (rst_in) // R1
    s_low_only |=> low_steer_word == $past(reg_wdata_in))
    else $error("low word not stored");
  AST_HIGH_STORE: assert property (@(posedge core_clk_in) disable iff (rst_in) // R2
    s_high_wr |=> high_steer_word == $past(reg_wdata_in[9:0]))
    else $error("high word not stored");
  AST_RESET_CLEAR: assert property (@(posedge core_clk_in) // R3
    $fell(rst_in) |-> applied_steer == 26'h0000000 && low_steer_word == 16'h0000)
    else $error("steer word not cleared at reset");
  AST_LOW_NO_APPLY: assert property (@(posedge core_clk_in) disable iff (rst_in) // R6
    s_low_only |=> $stable(applied_steer))
    else $error("low write changed applied word");
  AST_PAIR_CAPTURE: assert property (@(posedge core_clk_in) disable iff (rst_in) // R15
    s_high_wr |=> applied_steer == {$past(reg_wdata_in[9:0]), $past(low_steer_word)})
    else $error("applied word not captured as a pair");
  AST_GATE_SW: assert property (@(posedge core_clk_in) disable iff (rst_in) // R8
    s_high_wr ##0 !hw_gate_mode_in |=> output_gate_out == $past(reg_wdata_in[10]))
    else $error("software gate bit not taken");
  AST_GATE_HW: assert property (@(posedge core_clk_in) disable iff (rst_in) // R9
    hw_gate_mode_in |=> $stable(output_gate_out))
    else $error("gate changed in hardware mode");
  AST_HIGH_READ: assert property (@(posedge core_clk_in) disable iff (rst_in) // R10
    reg_rd_in && reg_addr_in == dfcr_pkg::ADDR_HIGH_WORD |=> reg_rdata_out[15:11] == 5'h00)
    else $error("unused bits read nonzero");
  AST_PULL_START: assert property (@(posedge core_clk_in) disable iff (rst_in) // R12
    s_high_wr |=> pull_busy_out ##1 (pull_busy_out && !pull_settled_out) [*8])
    else $error("pull not busy after high write");
  AST_SIGNED: assert property (@(posedge core_clk_in) disable iff (rst_in) // R4
    state == dfcr_pkg::DFCR_SETTLE && applied_steer[25] && range_ppm(pull_range_in) != 12'd0
    && $stable(applied_steer) && $stable(pull_range_in) && $past(state) == dfcr_pkg::DFCR_DELAY
    |-> offset < 0)
    else $error("negative word gave non-negative offset");

endmodule // dfcr_regs
`default_nettype wire

/* dfcr_pkg.sv */
// Purpose: constants for the steering-word register bank
// Assumes: 16-bit register words, 100 MHz core clock
// Notes:   timing figures live here; the pull range code map is in the register module
package dfcr_pkg;
  localparam logic [7:0]  ADDR_LOW_WORD   = 8'h00;
  localparam logic [7:0]  ADDR_HIGH_WORD  = 8'h01;
  localparam int          HIGH_FIELD_W    = 10;
  localparam int          OE_BIT          = 10;
  localparam logic [15:0] RESET_WORD      = 16'h0000;
  localparam logic [25:0] RESET_STEER     = 26'h0000000;
  localparam int          CLK_PERIOD_NS   = 10;
  localparam int          DELAY_MAX_US    = 140;
  localparam int          SETTLE_MAX_US   = 20;
  localparam int          DELAY_CYCLES    = (DELAY_MAX_US * 1000) / CLK_PERIOD_NS;
  localparam int          SETTLE_CYCLES   = (SETTLE_MAX_US * 1000) / CLK_PERIOD_NS;
  localparam int          CNT_W           = 15;
  localparam int          PPM_W           = 12;
  localparam int          STEER_FRAC_SH   = 25;
  localparam int          OFFSET_W        = 38;
  typedef enum logic [1:0] {
    DFCR_IDLE,
    DFCR_DELAY,
    DFCR_SETTLE
  } dfcr_state_t;
endpackage : dfcr_pkg

/* dfcr_host.sv */
// Purpose: host model that writes and reads the steering-word registers
// Assumes: one-cycle strobes, read data valid one cycle after the read strobe
// Notes:   idle data lines carry the inverse of the last word, so stale data never passes
`timescale 1ns/1ns
`default_nettype none
module dfcr_host
(
  // clock
  input  wire logic        core_clk_in,
  // register access
  output var  logic        reg_wr_out,
  output var  logic        reg_rd_out,
  output var  logic [7:0]  reg_addr_out,
  output var  logic [15:0] reg_wdata_out,
  input  wire logic [15:0] reg_rdata_in
);
  initial
  begin
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_addr_out = 8'hff;
    reg_wdata_out = 16'h0000;
  end
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk_in);
    reg_wr_out <= 1'b1;
    reg_addr_out <= a;
    reg_wdata_out <= d;
    @(posedge core_clk_in);
    reg_wr_out <= 1'b0;
    reg_wdata_out <= ~d;
  endtask
  // low word first so the high write captures a complete word
  task automatic steer(input logic [25:0] w, input logic oe);
    wr(dfcr_pkg::ADDR_LOW_WORD, w[15:0]);
    wr(dfcr_pkg::ADDR_HIGH_WORD, {5'h00, oe, w[25:16]});
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge core_clk_in);
    reg_rd_out <= 1'b1;
    reg_addr_out <= a;
    @(posedge core_clk_in);
    reg_rd_out <= 1'b0;
    #1;
    d = reg_rdata_in;
  endtask
endmodule // dfcr_host
`default_nettype wire

/* dfcr_regs_tb.sv */
// Purpose: self-checking bench for the steering-word register bank
// Assumes: full-length pull delay and settle counts
// Notes:   two full pulls only, to keep the run short
`timescale 1ns/1ns
`default_nettype none
module dfcr_regs_tb;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic hw = 1'b0;
  logic [3:0] pull_range_in = 4'h3;
  wire logic wr, rd, gate, busy, settled;
  wire logic [7:0] addr;
  wire logic [15:0] wdata, rdata;
  wire logic [25:0] steer;
  wire logic signed [37:0] off;
  int fails = 0;
  int n_checks = 0;
  logic [31:0] rng = 32'h57f0;
  logic [15:0] d;
  logic [25:0] w = 26'h0;
  logic g = 1'b0;
  always #5 core_clk_in = ~core_clk_in;
  dfcr_host u_host (.core_clk_in(core_clk_in), .reg_wr_out(wr), .reg_rd_out(rd), .reg_addr_out(addr),
    .reg_wdata_out(wdata), .reg_rdata_in(rdata));
  dfcr_regs u_dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .hw_gate_mode_in(hw),
    .pull_range_in(pull_range_in), .output_gate_out(gate), .applied_steer_out(steer),
    .freq_offset_out(off), .pull_busy_out(busy), .pull_settled_out(settled));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [37:0] exp_off(input logic [25:0] v, input logic [3:0] c);
    int p;
    case (c)
      4'h3: p = 25;
      4'h4: p = 50;
      4'h5: p = 80;
      4'h6: p = 100;
      4'hd: p = 1200;
      4'he: p = 1600;
      4'hf: p = 3200;
      default: p = 0;
    endcase
    return $signed({{12{v[25]}}, v}) * 38'(p);
  endfunction
  task automatic check(input string what, input logic [37:0] seen, input logic [37:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // pull timing is measured from the edge after the high write
  task automatic pull(input logic [25:0] v, input logic [3:0] c);
    int k;
    int t;
    logic [37:0] prev;
    prev = off;
    t = 0;
    pull_range_in <= c;
    u_host.steer(v, 1'b1);
    #1;
    check("busy", busy, 1'b1);
    for (k = 0; k < 17000 && settled !== 1'b1; k++)
    begin
      @(posedge core_clk_in);
      #1;
      if (t == 0 && off !== prev) t = k + 1;
    end
    if (settled !== 1'b1)
    begin
      fails++;
      end_of_test();
    end
    check("delay", t > 0 && t <= 14000, 1'b1);
    check("settle", k > t && k - t <= 2000, 1'b1);
    check("offset", off, exp_off(v, c));
    $display("pull test done");
  endtask
  initial
  begin
    repeat (10) @(posedge core_clk_in);
    rst_in <= 1'b0;
    u_host.rd(8'h01, d);
    check("high reset", d, 16'h0000);
    check("gate reset", gate, 1'b0);
    check("steer reset", steer, 26'h0);
    for (int i = 0; i < 12; i++)
    begin
      rng = xs(rng);
      u_host.wr(8'h00, rng[15:0]);
      u_host.rd(8'h00, d);
      check("low word", d, rng[15:0]);
      check("steer held", steer, w);
      hw <= rng[31];
      u_host.wr(8'h01, rng[31:16]);
      if (!hw) g = rng[26];
      u_host.rd(8'h01, d);
      w = rng[25:0];
      check("high word", d, {5'h00, g, rng[25:16]});
      check("steer", steer, w);
      check("gate", gate, g);
    end
    hw <= 1'b0;
    u_host.rd(8'h07, d);
    check("unmapped", d, 16'h0000);
    $display("register test done");
    rng = xs(rng);
    pull({1'b1, rng[24:0]}, 4'hf);
    pull({1'b0, rng[31:7]}, 4'h3);
    // reset in mid-pull must drop every output back to its power-up value
    u_host.steer(26'h2000001, 1'b1);
    repeat (5) @(posedge core_clk_in);
    rst_in <= 1'b1;
    repeat (3) @(posedge core_clk_in);
    rst_in <= 1'b0;
    #1;
    check("busy cleared", busy, 1'b0);
    check("settled reset", settled, 1'b1);
    check("steer cleared", steer, 26'h0);
    check("offset cleared", off, 38'h0);
    check("gate cleared", gate, 1'b0);
    u_host.rd(8'h00, d);
    check("low cleared", d, 16'h0000);
    $display("reset test done");
    end_of_test();
  end
endmodule // dfcr_regs_tb
`default_nettype wire
